// ### rtl/sensor_port_pkg.sv
// Constants shared by both ends of the three-wire sensor serial port
// Behaviour
// - Only the host ever starts a transfer
// - Host always generates the serial clock
// - Deselected sensor ignores pins, releases data line
// - Port active only while chip select low
// - Pins may be shared with other slaves
// - Chip select rise aborts, port returns idle
// - Host raises chip select to recover
// - Host keeps normal delays after an abort
// - Host frames each transaction with chip select
// - Chip select rise ends burst; locked until then
// - Write: address byte MSB one, data byte
// - Sensor samples data on rising clock edges
// - Read: address byte MSB zero, sensor answers
// - Sensor changes read bits on falling edges
// - Read bit held until next falling edge
// - At least 30 us between two writes
// - At least 20 us from write to read
// - Read address to data wait 4-10 us
// - At least 500 ns after a read
package sensor_port_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DIR_BIT = 7;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_NONE = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [ADDR_W-1:0] BURST_ADDR = 7'h63;
    localparam logic [2:0] BURST_LAST = 3'h6;
    localparam logic [2:0] IDX_ONE = 3'h1;

    // ----------------------------------------------------------------
    // Timing, in ns and in mclk cycles
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int CNT_W = 12;
    localparam int T_SWW_NS = 30000;
    localparam int T_SRAD_MIN_NS = 4000;
    localparam int T_SRW_NS = 500;
    localparam int T_NCS_SCLK_NS = 120;
    localparam int T_SCLK_NCS_WR_NS = 20000;
    localparam int T_SCLK_NCS_RD_NS = 120;
    localparam int T_SCK_HALF_NS = 200;
    localparam logic [CNT_W-1:0] C_SWW = CNT_W'((T_SWW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_SRAD = CNT_W'((T_SRAD_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_SRW = CNT_W'((T_SRW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_NCS_SCLK = CNT_W'((T_NCS_SCLK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_SCLK_NCS_WR = CNT_W'((T_SCLK_NCS_WR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_SCLK_NCS_RD = CNT_W'((T_SCLK_NCS_RD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] C_HALF = CNT_W'((T_SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

endpackage : sensor_port_pkg

// ### rtl/spi3_if.sv
// Three-wire link between host and sensor port
`timescale 1ns/1ps
interface spi3_if;
    logic csN;
    logic sclk;
    logic hostOut;
    logic hostOeN;
    logic devOut;
    logic devOeN;
    logic sdio;

    // Shared data wire with pull-up when nobody drives
    assign sdio = !hostOeN ? hostOut : (!devOeN ? devOut : 1'b1);

    modport host (output csN, output sclk, output hostOut, output hostOeN, input sdio);
    modport device (input csN, input sclk, input sdio, output devOut, output devOeN);
endinterface : spi3_if

// ### rtl/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_d;

    always_comb
    begin
        meta_d = din;
        dout_d = meta_q;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            meta_q <= INIT;
            dout <= INIT;
        end
        else if (ce)
        begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end
endmodule : sync2

// ### rtl/sensor_port_dev.sv
// Sensor end of the three-wire serial port
`timescale 1ns/1ps
module sensor_port_dev (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    spi3_if.device link,
    output logic [sensor_port_pkg::ADDR_W-1:0] regAddr,
    output logic [sensor_port_pkg::DATA_W-1:0] regWrData,
    output logic regWr,
    output logic regRd,
    output logic [2:0] burstIdx,
    input wire logic [sensor_port_pkg::DATA_W-1:0] rdData
);
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_WDATA, D_RDATA, D_DONE} dstate_t;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic csS;
    logic sclkS;
    logic sdioS;

    sync2 #(
        .W(3),
        .INIT(3'h6)
    ) u_sync (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .din({link.csN, link.sclk, link.sdio}),
        .dout({csS, sclkS, sdioS})
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dstate_t state_q;
    dstate_t state_d;
    logic sclkPrev_q;
    logic sclkPrev_d;
    logic [3:0] bitCnt_q;
    logic [3:0] bitCnt_d;
    logic [7:0] inShift_q;
    logic [7:0] inShift_d;
    logic [7:0] outShift_q;
    logic [7:0] outShift_d;
    logic loadPend_q;
    logic loadPend_d;
    logic burst_q;
    logic burst_d;
    logic devOut_q;
    logic devOut_d;
    logic devOeN_q;
    logic devOeN_d;
    logic [sensor_port_pkg::ADDR_W-1:0] regAddr_q;
    logic [sensor_port_pkg::ADDR_W-1:0] regAddr_d;
    logic [sensor_port_pkg::DATA_W-1:0] regWrData_q;
    logic [sensor_port_pkg::DATA_W-1:0] regWrData_d;
    logic regWr_q;
    logic regWr_d;
    logic regRd_q;
    logic regRd_d;
    logic [2:0] burstIdx_q;
    logic [2:0] burstIdx_d;
    logic rise;
    logic fall;
    logic [7:0] inNext;

    // Edges found on the second synchroniser flop only
    assign rise = sclkS & ~sclkPrev_q;
    assign fall = ~sclkS & sclkPrev_q;
    assign inNext = {inShift_q[6:0], sdioS};

    always_comb
    begin
        state_d = state_q;
        sclkPrev_d = sclkS;
        bitCnt_d = bitCnt_q;
        inShift_d = inShift_q;
        outShift_d = outShift_q;
        loadPend_d = 1'b0;
        burst_d = burst_q;
        devOut_d = devOut_q;
        devOeN_d = devOeN_q;
        regAddr_d = regAddr_q;
        regWrData_d = regWrData_q;
        regWr_d = 1'b0;
        regRd_d = 1'b0;
        burstIdx_d = burstIdx_q;
        if (csS)
        begin
            // Deselect resets state, bit count and line drive, burst included
            state_d = D_IDLE;
            devOeN_d = 1'b1;
            burst_d = 1'b0;
            bitCnt_d = sensor_port_pkg::BIT_NONE;
        end
        else
        begin
            case (state_q)
                D_IDLE:
                begin
                    // Only a host select opens a frame
                    state_d = D_ADDR;
                    bitCnt_d = sensor_port_pkg::BIT_NONE;
                end
                D_ADDR:
                begin
                    if (rise)
                    begin
                        inShift_d = inNext;
                        bitCnt_d = bitCnt_q + sensor_port_pkg::BIT_ONE;
                        if (bitCnt_q == sensor_port_pkg::BIT_LAST)
                        begin
                            bitCnt_d = sensor_port_pkg::BIT_NONE;
                            regAddr_d = inNext[sensor_port_pkg::ADDR_W-1:0];
                            if (inNext[sensor_port_pkg::DIR_BIT])
                            begin
                                state_d = D_WDATA;
                            end
                            else
                            begin
                                // Data is latched right after the last address bit
                                state_d = D_RDATA;
                                regRd_d = 1'b1;
                                loadPend_d = 1'b1;
                                burstIdx_d = 3'h0;
                                burst_d = (inNext[sensor_port_pkg::ADDR_W-1:0] == sensor_port_pkg::BURST_ADDR);
                            end
                        end
                    end
                end
                D_WDATA:
                begin
                    if (rise)
                    begin
                        inShift_d = inNext;
                        bitCnt_d = bitCnt_q + sensor_port_pkg::BIT_ONE;
                        if (bitCnt_q == sensor_port_pkg::BIT_LAST)
                        begin
                            regWrData_d = inNext;
                            regWr_d = 1'b1;
                            state_d = D_DONE;
                        end
                    end
                end
                D_RDATA:
                begin
                    if (loadPend_q)
                    begin
                        outShift_d = rdData;
                    end
                    else if (fall && bitCnt_q <= sensor_port_pkg::BIT_LAST)
                    begin
                        // New bit only on a falling edge, so it holds a full high phase
                        devOut_d = outShift_q[7];
                        devOeN_d = 1'b0;
                        outShift_d = {outShift_q[6:0], 1'b0};
                        bitCnt_d = bitCnt_q + sensor_port_pkg::BIT_ONE;
                    end
                    else if (rise && bitCnt_q > sensor_port_pkg::BIT_LAST)
                    begin
                        bitCnt_d = sensor_port_pkg::BIT_NONE;
                        if (burst_q && burstIdx_q != sensor_port_pkg::BURST_LAST)
                        begin
                            // Next burst byte fetched without a new address
                            burstIdx_d = burstIdx_q + sensor_port_pkg::IDX_ONE;
                            regRd_d = 1'b1;
                            loadPend_d = 1'b1;
                        end
                        else
                        begin
                            state_d = D_DONE;
                        end
                    end
                end
                D_DONE:
                begin
                    // Port stays locked until deselect, also after a burst
                    if (fall)
                    begin
                        devOeN_d = 1'b1;
                    end
                end
                default:
                begin
                    state_d = D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_q <= D_IDLE;
            sclkPrev_q <= 1'b1;
            bitCnt_q <= sensor_port_pkg::BIT_NONE;
            inShift_q <= 8'h00;
            outShift_q <= 8'h00;
            loadPend_q <= 1'b0;
            burst_q <= 1'b0;
            devOut_q <= 1'b1;
            devOeN_q <= 1'b1;
            regAddr_q <= 7'h00;
            regWrData_q <= 8'h00;
            regWr_q <= 1'b0;
            regRd_q <= 1'b0;
            burstIdx_q <= 3'h0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            sclkPrev_q <= sclkPrev_d;
            bitCnt_q <= bitCnt_d;
            inShift_q <= inShift_d;
            outShift_q <= outShift_d;
            loadPend_q <= loadPend_d;
            burst_q <= burst_d;
            devOut_q <= devOut_d;
            devOeN_q <= devOeN_d;
            regAddr_q <= regAddr_d;
            regWrData_q <= regWrData_d;
            regWr_q <= regWr_d;
            regRd_q <= regRd_d;
            burstIdx_q <= burstIdx_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Never drives unless selected, so other slaves can share the wires
    assign link.devOut = devOut_q;
    assign link.devOeN = devOeN_q;
    assign regAddr = regAddr_q;
    assign regWrData = regWrData_q;
    assign regWr = regWr_q;
    assign regRd = regRd_q;
    assign burstIdx = burstIdx_q;

endmodule : sensor_port_dev

// ### rtl/sensor_port_host.sv
// Host end of the three-wire serial port
`timescale 1ns/1ps
module sensor_port_host (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    spi3_if.host link,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [sensor_port_pkg::ADDR_W-1:0] cmdAddr,
    input wire logic [sensor_port_pkg::DATA_W-1:0] cmdData,
    input wire logic [2:0] cmdCount,
    output logic cmdReady,
    output logic rspValid,
    output logic [sensor_port_pkg::DATA_W-1:0] rspData
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_SRAD, H_TAIL, H_GAP} hstate_t;

    logic sdioS;

    sync2 #(
        .W(1),
        .INIT(1'b1)
    ) u_sync (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .din(link.sdio),
        .dout(sdioS)
    );

    hstate_t state_q, state_d;
    logic [sensor_port_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d, data_q, data_d;
    logic [2:0] left_q, left_d;
    logic isWr_q, isWr_d, dataPh_q, dataPh_d;
    logic csN_q, csN_d, sclk_q, sclk_d, out_q, out_d, oeN_q, oeN_d;
    logic ready_q, ready_d, rspValid_q, rspValid_d;
    logic [7:0] rspData_q, rspData_d;
    logic goLow;

    always_comb
    begin
        state_d = state_q;
        cnt_d = (cnt_q == sensor_port_pkg::CNT_ZERO) ? cnt_q : cnt_q - sensor_port_pkg::CNT_ONE;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        data_d = data_q;
        left_d = left_q;
        isWr_d = isWr_q;
        dataPh_d = dataPh_q;
        csN_d = csN_q;
        sclk_d = sclk_q;
        out_d = out_q;
        oeN_d = oeN_q;
        ready_d = 1'b0;
        rspValid_d = 1'b0;
        rspData_d = rspData_q;
        goLow = 1'b0;
        case (state_q)
            H_IDLE:
            begin
                ready_d = 1'b1;
                if (cmdValid && ready_q)
                begin
                    // Select only around a transaction
                    ready_d = 1'b0;
                    csN_d = 1'b0;
                    isWr_d = cmdWrite;
                    shift_d = {cmdWrite, cmdAddr};
                    data_d = cmdData;
                    left_d = (cmdCount == 3'h0) ? sensor_port_pkg::IDX_ONE : cmdCount;
                    dataPh_d = 1'b0;
                    bitCnt_d = sensor_port_pkg::BIT_NONE;
                    cnt_d = sensor_port_pkg::C_NCS_SCLK;
                    state_d = H_SETUP;
                end
            end
            H_SETUP, H_SRAD:
            begin
                // Read data waits the address-to-data minimum
                goLow = (cnt_q == sensor_port_pkg::CNT_ZERO);
            end
            H_LOW:
            begin
                if (cnt_q == sensor_port_pkg::CNT_ZERO)
                begin
                    sclk_d = 1'b1;
                    cnt_d = sensor_port_pkg::C_HALF;
                    state_d = H_HIGH;
                    if (dataPh_q && !isWr_q)
                    begin
                        shift_d = {shift_q[6:0], sdioS};
                    end
                end
            end
            H_HIGH:
            begin
                if (cnt_q == sensor_port_pkg::CNT_ZERO)
                begin
                    bitCnt_d = bitCnt_q + sensor_port_pkg::BIT_ONE;
                    goLow = 1'b1;
                    if (bitCnt_q == sensor_port_pkg::BIT_LAST)
                    begin
                        bitCnt_d = sensor_port_pkg::BIT_NONE;
                        if (!dataPh_q)
                        begin
                            dataPh_d = 1'b1;
                            shift_d = data_q;
                            if (!isWr_q)
                            begin
                                goLow = 1'b0;
                                oeN_d = 1'b1;
                                cnt_d = sensor_port_pkg::C_SRAD;
                                state_d = H_SRAD;
                            end
                        end
                        else
                        begin
                            if (!isWr_q)
                            begin
                                rspValid_d = 1'b1;
                                rspData_d = shift_q;
                            end
                            left_d = left_q - sensor_port_pkg::IDX_ONE;
                            if (isWr_q || left_q == sensor_port_pkg::IDX_ONE)
                            begin
                                goLow = 1'b0;
                                oeN_d = 1'b1;
                                cnt_d = isWr_q ? sensor_port_pkg::C_SCLK_NCS_WR : sensor_port_pkg::C_SCLK_NCS_RD;
                                state_d = H_TAIL;
                            end
                        end
                    end
                end
            end
            H_TAIL:
            begin
                if (cnt_q == sensor_port_pkg::CNT_ZERO)
                begin
                    // Raising select also ends a burst
                    csN_d = 1'b1;
                    cnt_d = isWr_q ? sensor_port_pkg::C_SWW : sensor_port_pkg::C_SRW;
                    state_d = H_GAP;
                end
            end
            default:
            begin
                if (cnt_q == sensor_port_pkg::CNT_ZERO)
                begin
                    state_d = H_IDLE;
                end
            end
        endcase
        if (goLow)
        begin
            // Host makes the clock; drives on falling edge, MSB first
            sclk_d = 1'b0;
            cnt_d = sensor_port_pkg::C_HALF;
            state_d = H_LOW;
            oeN_d = dataPh_d && !isWr_q;
            out_d = shift_d[7];
            if (!oeN_d)
            begin
                shift_d = {shift_d[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            // Reset leaves select high, which also recovers the sensor port
            state_q <= H_IDLE;
            cnt_q <= sensor_port_pkg::CNT_ZERO;
            bitCnt_q <= sensor_port_pkg::BIT_NONE;
            shift_q <= 8'h00;
            data_q <= 8'h00;
            left_q <= 3'h0;
            isWr_q <= 1'b0;
            dataPh_q <= 1'b0;
            csN_q <= 1'b1;
            sclk_q <= 1'b1;
            out_q <= 1'b1;
            oeN_q <= 1'b1;
            ready_q <= 1'b0;
            rspValid_q <= 1'b0;
            rspData_q <= 8'h00;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            data_q <= data_d;
            left_q <= left_d;
            isWr_q <= isWr_d;
            dataPh_q <= dataPh_d;
            csN_q <= csN_d;
            sclk_q <= sclk_d;
            out_q <= out_d;
            oeN_q <= oeN_d;
            ready_q <= ready_d;
            rspValid_q <= rspValid_d;
            rspData_q <= rspData_d;
        end
    end

    assign link.csN = csN_q;
    assign link.sclk = sclk_q;
    assign link.hostOut = out_q;
    assign link.hostOeN = oeN_q;
    assign cmdReady = ready_q;
    assign rspValid = rspValid_q;
    assign rspData = rspData_q;

endmodule : sensor_port_host

// ### verification/sensor_port_props.sv
// Concurrent checks on the three-wire link between host and sensor
`timescale 1ns/1ps
module sensor_port_props (
    input wire logic mclk,
    input wire logic srst,
    input wire logic csN,
    input wire logic sclk,
    input wire logic hostOut,
    input wire logic hostOeN,
    input wire logic devOut,
    input wire logic devOeN
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Cycles with select high, saturated so reset counts as a long gap
    int highCnt;
    always_ff @(posedge mclk)
    begin
        if (srst)
            highCnt <= 4000;
        else if (!csN)
            highCnt <= 0;
        else if (highCnt < 4000)
            highCnt <= highCnt + 1;
    end

    // ------------------------------------------------
    // Link checks
    // ------------------------------------------------
    // Sync lag of about three cycles, so allow six
    a_deselect_release: assert property (csN [*6] |-> devOeN)
        else $error("sensor drives while deselected");
    a_single_driver: assert property (!(!hostOeN && !devOeN))
        else $error("both ends drive the data line");
    a_clock_parked: assert property (csN |-> sclk)
        else $error("serial clock moves while deselected");
    a_select_first: assert property ($fell(devOeN) |-> !csN && hostOeN)
        else $error("sensor drives without select");
    a_out_on_fall: assert property (!devOeN && $changed(devOut) |-> !sclk)
        else $error("sensor output changed while clock high");
    a_out_hold: assert property (!devOeN && sclk |-> $stable(devOut))
        else $error("sensor output not held");
    a_abort_release: assert property ($rose(csN) |-> ##[0:5] devOeN)
        else $error("sensor kept line after deselect");
    a_host_setup: assert property ($rose(sclk) && !hostOeN |-> $stable(hostOut))
        else $error("host data moved at sampling edge");
    a_gap_kept: assert property ($fell(csN) |-> highCnt >= int'(sensor_port_pkg::C_SRW))
        else $error("select high too briefly between frames");
    c_read_turn: cover property ($fell(devOeN));
    c_frame_end: cover property ($rose(csN));
    c_write_bit: cover property ($rose(sclk) && !hostOeN);
endmodule : sensor_port_props

// ### verification/three_wire_sensor_serial_port_test.sv
// Bench joining host and sensor ends, plus a hand-driven link to a second sensor
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module three_wire_sensor_serial_port_test;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdWrite = 1'b0;
    logic cmdReady, rspValid, regWr, regRd, regWr2, regRd2;
    logic [6:0] cmdAddr = 7'h00;
    logic [6:0] regAddr, regAddr2;
    logic [7:0] cmdData = 8'h00;
    logic [7:0] rdBase = 8'h00;
    logic [7:0] rspData, regWrData, regWrData2, rdData;
    logic [2:0] cmdCount = 3'h1;
    logic [2:0] burstIdx, burstIdx2;
    logic [15:0] wireBits = 16'h0000;
    logic [7:0] rsp[$];
    int mismatches = 0;
    int nTests = 0;
    int nWr = 0;
    int nWr2 = 0;
    int nRd = 0;
    int nRd2 = 0;
    spi3_if link ();
    spi3_if link2 ();
    always #5 mclk = ~mclk;
    assign rdData = rdBase + {5'h00, burstIdx};
    sensor_port_host sensor_port_host_inst (.mclk(mclk), .srst(srst), .ce(1'b1), .link(link.host),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCount(cmdCount),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
    sensor_port_dev sensor_port_dev_inst (.mclk(mclk), .srst(srst), .ce(1'b1), .link(link.device),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .burstIdx(burstIdx), .rdData(rdData));
    // Second sensor faces the bench, which can break the framing
    sensor_port_dev sensor_port_dev_inst2 (.mclk(mclk), .srst(srst), .ce(1'b1), .link(link2.device),
        .regAddr(regAddr2), .regWrData(regWrData2), .regWr(regWr2), .regRd(regRd2), .burstIdx(burstIdx2),
        .rdData(8'h5A));
    sensor_port_props sensor_port_props_inst (.mclk(mclk), .srst(srst), .csN(link.csN), .sclk(link.sclk),
        .hostOut(link.hostOut), .hostOeN(link.hostOeN), .devOut(link.devOut), .devOeN(link.devOeN));

    // ------------------------------------------------
    // Monitors
    // ------------------------------------------------
    always @(posedge link.sclk) if (!link.csN) wireBits <= {wireBits[14:0], link.sdio};
    always @(posedge mclk)
    begin
        if (rspValid) rsp.push_back(rspData);
        if (regWr) nWr++;
        if (regWr2) nWr2++;
        if (regRd) nRd++;
        if (regRd2) nRd2++;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Returns once the host is ready again, so the whole gap is kept
    task automatic run_cmd(input logic w, input logic [6:0] a, input logic [2:0] n);
        int i;
        i = 0;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdAddr <= a;
        cmdData <= 8'hA5;
        cmdCount <= n;
        do @(posedge mclk); while (cmdReady !== 1'b1 && i++ < 10000);
        cmdValid <= 1'b0;
        repeat (2) @(posedge mclk);
        while (cmdReady !== 1'b1 && i++ < 20000) @(posedge mclk);
        if (i >= 20000)
        begin
            mismatches++;
            $display("wrong value at %0t: command never finished", $time);
            report_and_stop();
        end
    endtask : run_cmd

    // 170 ns link period: data moves on fall, sampled on rise
    task automatic send_bit2(input logic b);
        @(posedge mclk);
        link2.sclk <= 1'b0;
        link2.hostOut <= b;
        repeat (8) @(posedge mclk);
        link2.sclk <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : send_bit2

    task automatic frame2(input logic [15:0] bits, input int n, input int tail);
        @(posedge mclk);
        link2.csN <= 1'b0;
        link2.hostOeN <= 1'b0;
        repeat (12) @(posedge mclk);
        for (int k = 15; k > 15 - n; k--) send_bit2(bits[k]);
        repeat (tail) @(posedge mclk);
        link2.csN <= 1'b1;
        link2.hostOeN <= 1'b1;
    endtask : frame2

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic test_write;
        run_cmd(1'b1, 7'h0D, 3'h1);
        `CHK(nWr, 1)
        `CHK({regAddr, regWrData}, 15'h0DA5)
        `CHK(wireBits, 16'h8DA5)
    endtask : test_write

    task automatic test_read;
        rdBase <= 8'h3C;
        run_cmd(1'b0, 7'h05, 3'h1);
        `CHK(rsp.size(), 1)
        `CHK(rsp[0], 8'h3C)
        `CHK(wireBits, 16'h053C)
        `CHK(nWr, 1)
        `CHK(nRd, 1)
        rsp.delete();
    endtask : test_read

    task automatic test_burst;
        rdBase <= 8'h70;
        run_cmd(1'b0, 7'h63, 3'h7);
        `CHK(rsp.size(), 7)
        for (int k = 0; k < 7; k++) `CHK(rsp[k], 8'h70 + 8'(k))
        `CHK(nRd, 8)
        rsp.delete();
        // A zero count must still fetch one byte
        run_cmd(1'b0, 7'h05, 3'h0);
        `CHK(rsp.size(), 1)
        `CHK(rsp[0], 8'h70)
        rsp.delete();
    endtask : test_burst

    task automatic test_abort;
        link2.hostOeN <= 1'b0;
        for (int k = 0; k < 16; k++) send_bit2(k[0]);
        `CHK(link2.devOeN, 1'b1)
        `CHK(nRd2, 0)
        link2.hostOeN <= 1'b1;
        frame2(16'h8DFF, 4, 20);
        repeat (3000) @(posedge mclk);
        frame2(16'h9155, 16, 2000);
        repeat (20) @(posedge mclk);
        `CHK(nWr2, 1)
        `CHK({regAddr2, regWrData2}, 15'h1155)
    endtask : test_abort

    initial
    begin
        link2.csN = 1'b1;
        link2.sclk = 1'b1;
        link2.hostOut = 1'b1;
        link2.hostOeN = 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        test_write();
        test_read();
        test_burst();
        test_abort();
        report_and_stop();
    end
endmodule : three_wire_sensor_serial_port_test
